// file: shared/lan_cfg_consts.svh
`ifndef LAN_CFG_CONSTS_SVH
`define LAN_CFG_CONSTS_SVH
`define OFS_CFG_A 5'h0a
`define OFS_CFG_B 5'h0b
`define OFS_CFG_C_IO 5'h0c
`define OFS_CFG_C_MEM 5'h1c
`define A_PREFETCH 6
`define A_MEMSEL 7
`define B_LINK 2
`define B_IOTIME 3
`define B_RDYTIME 4
`define B_FAULT 5
`define B_ROMWR 6
`define B_SAVE 7
`define PHYS_TP_STD 2'h0
`define PHYS_THIN 2'h1
`define PHYS_AUI 2'h2
`define PHYS_TP_RED 2'h3
`define RST_CFG_A 8'h00
`define RST_CFG_B 8'h00
`define RST_CFG_C 4'h0
`define WIN_BASE_SEG 16'hc000
`define WIN_STEP_SMALL 16'h0400
`define WIN_STEP_MID 16'h0800
`define WIN_BASE_HI_SEG 16'hd000
`define WIN_CODE_SMALL 4'h2
`define WIN_CODE_MID 4'ha
`define WIN_CODE_BIG 4'he
`define WIN_SIZE_8K 20'h02000
`define WIN_SIZE_16K 20'h04000
`define WIN_SIZE_32K 20'h08000
`define WIN_SIZE_64K 20'h10000
`endif

// file: shared/lan_cfg_pkg.sv
package lan_cfg_pkg;
	typedef struct packed {
		logic [7:0] cfg_a;
		logic [7:0] cfg_b;
		logic [3:0] cfg_c;
		logic unlock_a;
		logic unlock_b;
		logic [7:0] rdata;
		logic rbc0_wr;
		logic rbc1_wr;
		logic [7:0] rbc_data;
		logic save_start;
		logic bale_seen;
		logic cmd_d;
		logic chrdy_d;
		logic [7:0] sd_out;
		logic sd_oe;
		logic rom_we;
		logic prefetch;
	} cfg_state_type;
endpackage

// file: shared/boot_win_if.sv
interface boot_win_if;
	logic [3:0] window_sel;
	logic shared_mode;
	logic [19:0] mem_addr;
	logic hit;
	modport owner(output window_sel, output shared_mode, output mem_addr, input hit);
	modport decoder(input window_sel, input shared_mode, input mem_addr, output hit);
endinterface

// file: rtl/boot_window_decode.sv
`include "lan_cfg_consts.svh"
module boot_window_decode (
	boot_win_if.decoder win
);
	logic [15:0] base_seg;
	logic [19:0] base_addr;
	logic [19:0] size;
	logic [19:0] offset;
	logic [3:0] idx;

	// Window base and size from the select code, small window doubled from 8K to 16K in shared mode
	always_comb begin
		base_seg = `WIN_BASE_SEG;
		size = 20'h00000;
		idx = 4'h0;
		if (win.window_sel >= `WIN_CODE_BIG) begin
			base_seg = win.window_sel[0] ? `WIN_BASE_HI_SEG : `WIN_BASE_SEG;
			size = `WIN_SIZE_64K;
		end else if (win.window_sel >= `WIN_CODE_MID) begin
			idx = win.window_sel - `WIN_CODE_MID;
			base_seg = `WIN_BASE_SEG + 16'(idx) * `WIN_STEP_MID;
			size = `WIN_SIZE_32K;
		end else if (win.window_sel >= `WIN_CODE_SMALL) begin
			idx = win.window_sel - `WIN_CODE_SMALL;
			base_seg = `WIN_BASE_SEG + 16'(idx) * `WIN_STEP_SMALL;
			size = win.shared_mode ? `WIN_SIZE_16K : `WIN_SIZE_8K;
		end
		base_addr = {base_seg, 4'h0};
		offset = win.mem_addr - base_addr;
	end

	// No window for codes 000x
	assign win.hit = (size != 20'h00000) && (win.mem_addr >= base_addr) && (offset < size);
endmodule

// file: rtl/lan_config_regs_ab_c.sv
`include "lan_cfg_consts.svh"
module lan_config_regs_ab_c
	import lan_cfg_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic [4:0] reg_addr,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic page0_sel,
	input wire logic extended_page_enable,
	input wire logic page_select_bit,
	output logic [7:0] reg_rdata,
	output logic rbc0_write,
	output logic rbc1_write,
	output logic [7:0] rbc_wdata,
	input wire logic nvm_load_valid,
	input wire logic [7:0] nvm_load_a,
	input wire logic [7:0] nvm_load_b,
	input wire logic [3:0] nvm_load_c,
	input wire logic nvm_save_done,
	output logic nvm_save_start,
	output logic fast_port_prefetch,
	output logic shared_memory_select,
	input wire logic port_read_start,
	input wire logic port_read_done,
	output logic port_prefetch_req,
	output logic [1:0] medium_interface_select,
	output logic twisted_pair_interface,
	output logic thin_converter_enable,
	output logic aui_select,
	output logic reduced_squelch,
	output logic link_test_disable,
	input wire logic tp_link_good,
	output logic link_good_status,
	output logic link_led_n,
	input wire logic io_read_strobe_n,
	input wire logic io_write_strobe_n,
	input wire logic mem_read_strobe_n,
	input wire logic mem_write_strobe_n,
	input wire logic bale,
	input wire logic wide_io_decode,
	output logic wide_io_ack_n,
	input wire logic dev_wait_req,
	output logic chrdy_out,
	output logic chrdy_oe,
	output logic bus_fault_flag,
	input wire logic [19:0] mem_addr,
	input wire logic [7:0] boot_rom_data,
	output logic boot_rom_write,
	output logic [7:0] sys_data_out,
	output logic sys_data_oe
);
	cfg_state_type st_r;
	cfg_state_type st_nxt;
	boot_win_if win();
	logic io_strobe;
	logic cmd_active;
	logic cycle_end;
	logic fault_set;
	logic fault_clr;
	logic hit_a;
	logic hit_b;
	logic hit_c;
	logic c_open;

	// Boot window decode on the host memory address
	assign win.window_sel = st_r.cfg_c;
	assign win.shared_mode = st_r.cfg_a[`A_MEMSEL];
	assign win.mem_addr = mem_addr;
	boot_window_decode u_win (
		.win(win)
	);

	// Host strobes and cycle boundaries
	assign io_strobe = ~io_read_strobe_n | ~io_write_strobe_n;
	assign cmd_active = io_strobe | ~mem_read_strobe_n | ~mem_write_strobe_n;
	assign cycle_end = st_r.cmd_d & ~cmd_active;

	// Address hits for the three registers
	assign hit_a = page0_sel && reg_addr == `OFS_CFG_A;
	assign hit_b = page0_sel && reg_addr == `OFS_CFG_B;
	assign c_open = extended_page_enable & page_select_bit;
	assign hit_c = c_open && reg_addr == (st_r.cfg_a[`A_MEMSEL] ?
		`OFS_CFG_C_MEM : `OFS_CFG_C_IO);

	// Host ended a cycle while we still held ready low
	assign fault_set = cycle_end & st_r.chrdy_d & dev_wait_req;
	assign fault_clr = reg_wr & hit_b & st_r.unlock_b & reg_wdata[`B_FAULT];

	// Next-state logic
	always_comb begin
		st_nxt = st_r;
		st_nxt.rbc0_wr = 1'b0;
		st_nxt.rbc1_wr = 1'b0;
		st_nxt.save_start = 1'b0;
		st_nxt.rom_we = 1'b0;
		st_nxt.prefetch = 1'b0;
		st_nxt.cmd_d = cmd_active;
		st_nxt.chrdy_d = chrdy_oe;
		// Any access breaks the read-then-write unlock
		if (reg_rd | reg_wr) begin
			st_nxt.unlock_a = reg_rd & hit_a;
			st_nxt.unlock_b = reg_rd & hit_b;
		end
		// Register reads
		if (reg_rd) begin
			st_nxt.rdata = 8'h00;
			if (hit_a) begin
				st_nxt.rdata = st_r.cfg_a;
			end else if (hit_b) begin
				st_nxt.rdata = st_r.cfg_b;
				st_nxt.rdata[`B_LINK] = link_good_status;
			end else if (hit_c) begin
				st_nxt.rdata = {4'h0, st_r.cfg_c};
			end
		end
		// Register writes, A and B redirected to the byte counters when not unlocked
		if (reg_wr) begin
			if (hit_a && st_r.unlock_a) begin
				st_nxt.cfg_a = reg_wdata;
			end else if (hit_a) begin
				st_nxt.rbc0_wr = 1'b1;
				st_nxt.rbc_data = reg_wdata;
			end else if (hit_b && st_r.unlock_b) begin
				st_nxt.cfg_b = reg_wdata;
				st_nxt.cfg_b[`B_FAULT] = st_r.cfg_b[`B_FAULT];
				st_nxt.save_start = reg_wdata[`B_SAVE];
			end else if (hit_b) begin
				st_nxt.rbc1_wr = 1'b1;
				st_nxt.rbc_data = reg_wdata;
			end else if (hit_c) begin
				st_nxt.cfg_c = reg_wdata[3:0];
			end
		end
		// Save trigger drops when the store sequence finishes; a new write wins
		if (nvm_save_done && !st_nxt.save_start) begin
			st_nxt.cfg_b[`B_SAVE] = 1'b0;
		end
		// Nonvolatile load after power-on, save trigger forced low
		if (nvm_load_valid) begin
			st_nxt.cfg_a = nvm_load_a;
			st_nxt.cfg_b = nvm_load_b;
			st_nxt.cfg_b[`B_SAVE] = 1'b0;
			st_nxt.cfg_c = nvm_load_c;
		end
		// Sticky fault flag, setting wins over clearing
		if (fault_clr) begin
			st_nxt.cfg_b[`B_FAULT] = 1'b0;
		end
		if (fault_set) begin
			st_nxt.cfg_b[`B_FAULT] = 1'b1;
		end
		// BALE seen within the current cycle
		if (bale) begin
			st_nxt.bale_seen = 1'b1;
		end else if (cycle_end) begin
			st_nxt.bale_seen = 1'b0;
		end
		// Boot ROM data returned on reads inside the window
		st_nxt.sd_oe = win.hit & ~mem_read_strobe_n;
		if (win.hit && !mem_read_strobe_n) begin
			st_nxt.sd_out = boot_rom_data;
		end
		st_nxt.rom_we = win.hit & ~mem_write_strobe_n & st_r.cfg_b[`B_ROMWR];
		// Data port prefetch, early when fast mode is on
		if (!st_r.cfg_a[`A_MEMSEL]) begin
			st_nxt.prefetch = st_r.cfg_a[`A_PREFETCH] ? port_read_start :
				port_read_done;
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (srst) begin
			st_r <= '{cfg_a: `RST_CFG_A, cfg_b: `RST_CFG_B, cfg_c: `RST_CFG_C,
				rdata: 8'h00, rbc_data: 8'h00, sd_out: 8'h00, default: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Register port outputs
	assign reg_rdata = st_r.rdata;
	assign rbc0_write = st_r.rbc0_wr;
	assign rbc1_write = st_r.rbc1_wr;
	assign rbc_wdata = st_r.rbc_data;
	assign nvm_save_start = st_r.save_start;

	// Host mode and prefetch
	assign fast_port_prefetch = st_r.cfg_a[`A_PREFETCH] & ~st_r.cfg_a[`A_MEMSEL];
	assign shared_memory_select = st_r.cfg_a[`A_MEMSEL];
	assign port_prefetch_req = st_r.prefetch;

	// Medium selection
	assign medium_interface_select = st_r.cfg_b[1:0];
	assign twisted_pair_interface = st_r.cfg_b[1:0] == `PHYS_TP_STD ||
		st_r.cfg_b[1:0] == `PHYS_TP_RED;
	assign thin_converter_enable = st_r.cfg_b[1:0] == `PHYS_THIN;
	assign aui_select = st_r.cfg_b[1:0] == `PHYS_AUI;
	assign reduced_squelch = st_r.cfg_b[1:0] == `PHYS_TP_RED;

	// Link test and status
	assign link_test_disable = st_r.cfg_b[`B_LINK];
	assign link_good_status = !aui_select && (link_test_disable || tp_link_good);
	assign link_led_n = ~link_good_status;

	// Host bus timing controls
	assign wide_io_ack_n = ~(wide_io_decode &
		(st_r.cfg_b[`B_IOTIME] ? io_strobe : 1'b1));
	assign chrdy_oe = dev_wait_req &
		(st_r.cfg_b[`B_RDYTIME] ? (st_r.bale_seen | bale) : cmd_active);
	assign chrdy_out = 1'b0; // Open drain, pulls ready low only
	assign bus_fault_flag = st_r.cfg_b[`B_FAULT];
	assign boot_rom_write = st_r.rom_we;
	assign sys_data_out = st_r.sd_out;
	assign sys_data_oe = st_r.sd_oe;

	// Checks
	a_unlock_write_a: assert property (@(posedge mclk) disable iff (srst)
		reg_wr && hit_a && st_r.unlock_a && !nvm_load_valid |=> st_r.cfg_a == $past(reg_wdata))
		else $error("register A not written after unlock");
	a_redirect_rbc0: assert property (@(posedge mclk) disable iff (srst)
		reg_wr && hit_a && !st_r.unlock_a |=> rbc0_write && $stable(st_r.cfg_a))
		else $error("locked write to 0AH not redirected");
	a_redirect_rbc1: assert property (@(posedge mclk) disable iff (srst)
		reg_wr && hit_b && !st_r.unlock_b |=> rbc1_write && rbc_wdata == $past(reg_wdata))
		else $error("locked write to 0BH not redirected");
	a_load_save_low: assert property (@(posedge mclk) disable iff (srst)
		nvm_load_valid |=> !st_r.cfg_b[`B_SAVE])
		else $error("save trigger set by load");
	a_fault_sticky: assert property (@(posedge mclk) disable iff (srst)
		bus_fault_flag && !fault_clr && !nvm_load_valid |=> bus_fault_flag)
		else $error("fault flag lost");
	a_fault_set_wins: assert property (@(posedge mclk) disable iff (srst)
		fault_set |=> bus_fault_flag)
		else $error("fault not flagged");
	a_fault_clear: assert property (@(posedge mclk) disable iff (srst)
		fault_clr && !fault_set && !nvm_load_valid |=> !bus_fault_flag)
		else $error("fault not cleared");
	a_link_aui_zero: assert property (@(posedge mclk) disable iff (srst)
		aui_select |-> !link_good_status && link_led_n)
		else $error("link reported in AUI mode");
	a_rom_write_gate: assert property (@(posedge mclk) disable iff (srst)
		boot_rom_write |-> $past(st_r.cfg_b[`B_ROMWR]) && $past(win.hit))
		else $error("boot ROM write without enable");
	a_save_pulse: assert property (@(posedge mclk) disable iff (srst)
		reg_wr && hit_b && st_r.unlock_b && reg_wdata[`B_SAVE] |=> nvm_save_start ##1 !nvm_save_start)
		else $error("save start not one pulse");
	a_c_locked: assert property (@(posedge mclk) disable iff (srst)
		reg_wr && !c_open && !nvm_load_valid |=> $stable(st_r.cfg_c))
		else $error("register C written outside enhanced mode");
	c_unlock_a: cover property (@(posedge mclk) reg_rd && hit_a ##1 reg_wr && hit_a);
	c_fault_set: cover property (@(posedge mclk) fault_set);
	c_rom_read: cover property (@(posedge mclk) sys_data_oe);
	c_save_done: cover property (@(posedge mclk) nvm_save_start ##[1:20] nvm_save_done);
endmodule

// file: test/nvm_rom_model.sv
module nvm_rom_model #(
	parameter int SAVE_CYC = 6
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic nvm_save_start,
	input wire logic load_req,
	input wire logic [7:0] load_b,
	input wire logic [19:0] mem_addr,
	output logic nvm_load_valid,
	output logic [7:0] nvm_load_a,
	output logic [7:0] nvm_load_b,
	output logic [3:0] nvm_load_c,
	output logic nvm_save_done,
	output logic [7:0] boot_rom_data
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	// Store sequence answers a fixed time after its start pulse
	always @(posedge mclk) begin
		nvm_save_done <= (cnt == 1);
		if (srst) cnt <= 0;
		else if (nvm_save_start) cnt <= SAVE_CYC;
		else if (cnt > 0) cnt <= cnt - 1;
	end
	// Load pulse on request; content lines carry junk outside it
	always @(posedge mclk) nvm_load_valid <= load_req & ~srst;
	assign nvm_load_a = nvm_load_valid ? 8'h00 : 8'hff;
	assign nvm_load_b = nvm_load_valid ? load_b : ~load_b; // Bench may preset the save bit
	assign nvm_load_c = nvm_load_valid ? 4'h2 : 4'hd;
	// ROM byte is a fixed pattern of the address
	assign boot_rom_data = mem_addr[7:0] ^ 8'h3c;
endmodule

// file: test/lan_config_regs_ab_c_tb.sv
`include "lan_cfg_consts.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %0t got %h exp %h", $time, g, e); end end
module lan_config_regs_ab_c_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, srst = 1, reg_rd = 0, reg_wr = 0, page0_sel = 1;
	logic extended_page_enable = 0, page_select_bit = 0, load_req = 0, tp_link_good = 1;
	logic [4:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, load_b = 0, reg_rdata, rbc_wdata, nvm_load_a, nvm_load_b, ev;
	logic [7:0] boot_rom_data, sys_data_out;
	logic [3:0] nvm_load_c;
	logic [1:0] medium_interface_select, pm = 0;
	logic [19:0] mem_addr = 0;
	logic port_read_start = 0, port_read_done = 0, io_read_strobe_n = 1, io_write_strobe_n = 1;
	logic mem_read_strobe_n = 1, mem_write_strobe_n = 1, bale = 0, wide_io_decode = 0;
	logic dev_wait_req = 0, nvm_load_valid, nvm_save_done, rbc0_write, rbc1_write;
	logic nvm_save_start, fast_port_prefetch, shared_memory_select, port_prefetch_req;
	logic twisted_pair_interface, thin_converter_enable, aui_select, reduced_squelch;
	logic link_test_disable, link_good_status, link_led_n, wide_io_ack_n, chrdy_out, chrdy_oe;
	logic bus_fault_flag, boot_rom_write, sys_data_oe;
	logic [7:0] exp_q[$];
	logic [3:0] tbl[4] = '{4'h8, 4'h4, 4'h2, 4'h9};
	logic [24:0] wt[9] = '{25'h1e_c1234, 25'h0e_bffff, 25'h19_ddfff, 25'h09_de000, 25'h01_c0000,
		25'h1a_c7fff, 25'h0a_c8000, 25'h1f_dffff, 25'h12_c1fff};
	int err_count = 0, total_checks = 0, seed = 32'h73e0, i;
	lan_config_regs_ab_c lan_config_regs_ab_c_i (.mclk, .srst, .reg_addr, .reg_rd, .reg_wr,
		.reg_wdata, .page0_sel, .extended_page_enable, .page_select_bit, .reg_rdata, .rbc0_write,
		.rbc1_write, .rbc_wdata, .nvm_load_valid, .nvm_load_a, .nvm_load_b, .nvm_load_c,
		.nvm_save_done, .nvm_save_start, .fast_port_prefetch, .shared_memory_select,
		.port_read_start, .port_read_done, .port_prefetch_req, .medium_interface_select,
		.twisted_pair_interface, .thin_converter_enable, .aui_select, .reduced_squelch,
		.link_test_disable, .tp_link_good, .link_good_status, .link_led_n, .io_read_strobe_n,
		.io_write_strobe_n, .mem_read_strobe_n, .mem_write_strobe_n, .bale, .wide_io_decode,
		.wide_io_ack_n, .dev_wait_req, .chrdy_out, .chrdy_oe, .bus_fault_flag, .mem_addr,
		.boot_rom_data, .boot_rom_write, .sys_data_out, .sys_data_oe);
	nvm_rom_model nvm_rom_model_i (.mclk, .srst, .nvm_save_start, .load_req, .load_b,
		.mem_addr, .nvm_load_valid, .nvm_load_a, .nvm_load_b, .nvm_load_c, .nvm_save_done,
		.boot_rom_data);
	// Clock
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	task automatic tick(int n = 1);
		repeat (n) @(posedge mclk);
		#2;
	endtask
	// Register access; strobe stays up so accesses can run back to back
	task automatic acc(logic w, logic [4:0] a, logic [7:0] d);
		reg_rd = !w;
		reg_wr = w;
		reg_addr = a;
		reg_wdata = d;
		tick();
	endtask
	task automatic rd(logic [4:0] a, logic [7:0] e);
		exp_q.push_back(e);
		acc(1'b0, a, 8'h00);
	endtask
	task automatic idle();
		reg_rd = 0;
		reg_wr = 0;
		tick();
	endtask
	// Register B readback with the link bit showing the pair status
	function automatic logic [7:0] bst(logic [7:0] v);
		return v | {5'h0, tp_link_good, 2'h0};
	endfunction
	task automatic prefetch(logic e);
		logic h;
		port_read_start = 1;
		tick();
		port_read_start = 0;
		h = port_prefetch_req;
		tick();
		`CHK(h | port_prefetch_req, e)
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Read data lands on the edge that samples the read strobe, so compare just after it
	always @(posedge mclk) begin
		#1;
		if (reg_rd) begin
			ev = exp_q.pop_front();
			`CHK(reg_rdata, ev)
		end
	end
	// Watchdog
	initial begin
		repeat (5000) @(posedge mclk);
		err_count++;
		conclude();
	end
	initial begin
		tick(16);
		srst = 0;
		rd(5'h03, 8'h00);
		rd(`OFS_CFG_A, 8'h00);
		wr_a: acc(1'b1, `OFS_CFG_A, 8'h40);
		idle();
		`CHK({fast_port_prefetch, shared_memory_select}, 2'b10)
		prefetch(1'b1);
		acc(1'b1, `OFS_CFG_A, 8'h80);
		`CHK({rbc0_write, rbc_wdata}, 9'h180)
		rd(`OFS_CFG_A, 8'h40);
		rd(`OFS_CFG_B, 8'h04);
		acc(1'b1, `OFS_CFG_A, 8'hc0);
		`CHK(rbc0_write, 1'b1)
		rd(`OFS_CFG_A, 8'h40);
		acc(1'b1, `OFS_CFG_A, 8'hc0);
		acc(1'b1, `OFS_CFG_B, 8'h5a);
		`CHK({rbc1_write, rbc_wdata}, 9'h15a)
		idle();
		`CHK({fast_port_prefetch, shared_memory_select}, 2'b01)
		prefetch(1'b0);
		for (i = 0; i < 4; i++) begin
			rd(`OFS_CFG_B, {5'h00, pm != 2'h2, pm}); // Link reads zero in AUI mode
			acc(1'b1, `OFS_CFG_B, 8'h04 | 8'(i));
			idle();
			pm = 2'(i);
			`CHK({twisted_pair_interface, thin_converter_enable, aui_select, reduced_squelch}, tbl[i])
			`CHK({medium_interface_select, link_test_disable, link_good_status}, {pm, 1'b1, pm != 2'h2})
		end
		tp_link_good = 1'($random(seed));
		rd(`OFS_CFG_B, 8'h07);
		acc(1'b1, `OFS_CFG_B, 8'h02);
		idle();
		`CHK({link_good_status, link_led_n}, 2'b01)
		rd(`OFS_CFG_B, 8'h02);
		acc(1'b1, `OFS_CFG_B, 8'h00);
		idle();
		`CHK(link_led_n, ~tp_link_good)
		wide_io_decode = 1;
		rd(`OFS_CFG_B, bst(8'h00));
		`CHK(wide_io_ack_n, 1'b0)
		acc(1'b1, `OFS_CFG_B, 8'h08);
		idle();
		`CHK(wide_io_ack_n, 1'b1)
		io_write_strobe_n = 0;
		tick();
		`CHK(wide_io_ack_n, 1'b0)
		io_write_strobe_n = 1;
		wide_io_decode = 0;
		dev_wait_req = 1;
		io_read_strobe_n = 0;
		tick();
		`CHK(chrdy_oe, 1'b1)
		`CHK(chrdy_out, 1'b0)
		io_read_strobe_n = 1;
		tick(2);
		`CHK(bus_fault_flag, 1'b1)
		dev_wait_req = 0;
		io_read_strobe_n = 0;
		tick();
		io_read_strobe_n = 1;
		tick();
		`CHK(bus_fault_flag, 1'b1)
		rd(`OFS_CFG_B, bst(8'h28));
		acc(1'b1, `OFS_CFG_B, 8'h08);
		idle();
		`CHK(bus_fault_flag, 1'b1)
		rd(`OFS_CFG_B, bst(8'h28));
		acc(1'b1, `OFS_CFG_B, 8'h38);
		idle();
		`CHK(bus_fault_flag, 1'b0)
		dev_wait_req = 1;
		bale = 1;
		tick();
		bale = 0;
		`CHK(chrdy_oe, 1'b1)
		dev_wait_req = 0;
		io_read_strobe_n = 0;
		tick();
		io_read_strobe_n = 1;
		rd(`OFS_CFG_B, bst(8'h18));
		acc(1'b1, `OFS_CFG_B, 8'h98); // Save alone, no ID write-back alongside
		`CHK(nvm_save_start, 1'b1)
		idle();
		for (i = 0; i < 20 && nvm_save_done !== 1'b1; i++) tick();
		tick();
		rd(`OFS_CFG_B, bst(8'h18));
		load_b = 8'h83;
		load_req = 1;
		idle();
		load_req = 0;
		tick();
		rd(`OFS_CFG_B, bst(8'h03));
		rd(`OFS_CFG_C_IO, 8'h00);
		acc(1'b1, `OFS_CFG_C_IO, 8'h0e);
		rd(`OFS_CFG_C_IO, 8'h00);
		extended_page_enable = 1;
		page_select_bit = 1;
		rd(`OFS_CFG_C_IO, 8'h02);
		for (i = 0; i < 9; i++) begin
			acc(1'b1, `OFS_CFG_C_IO, {4'h0, wt[i][23:20]});
			idle();
			mem_addr = wt[i][19:0];
			mem_read_strobe_n = 0;
			tick();
			`CHK(sys_data_oe, wt[i][24])
			if (wt[i][24]) `CHK(sys_data_out, mem_addr[7:0] ^ 8'h3c)
			mem_read_strobe_n = 1;
		end
		mem_write_strobe_n = 0;
		tick();
		`CHK(boot_rom_write, 1'b0)
		mem_write_strobe_n = 1;
		rd(`OFS_CFG_B, bst(8'h03));
		acc(1'b1, `OFS_CFG_B, 8'h43);
		idle();
		mem_write_strobe_n = 0;
		tick();
		`CHK(boot_rom_write, 1'b1)
		mem_write_strobe_n = 1;
		tick(2);
		conclude();
	end
endmodule
